/* File: rtl/spc_pkg.sv */
package spc_pkg;
    // register index and wishbone byte addresses (byte address is four times the index)
    localparam logic [7:0] SPC_SOFT_IDX = 8'h08;
    localparam logic [7:0] SPC_HARD_IDX = 8'h09;
    localparam int SPC_ADDR_W = 6;
    localparam logic [5:0] SPC_SOFT_ADDR = 6'h20;
    localparam logic [5:0] SPC_HARD_ADDR = 6'h24;
    // field positions
    localparam int SPC_SEL_BIT = 7;
    localparam int SPC_SOFT_LSB = 4;
    localparam int SPC_HARD_LSB = 2;
    // reset values
    localparam logic [2:0] SPC_SOFT_RST = 3'h0;
    localparam logic [5:0] SPC_HARD_RST = 6'h00;
    localparam logic SPC_SEL_RST = 1'b0;
    // three-level pin encoding
    typedef enum logic [1:0] {
        SPC_LVL_LOW = 2'h0,
        SPC_LVL_MID = 2'h1,
        SPC_LVL_HIGH = 2'h2
    } spc_level_type;
    // capture sequencing states
    typedef enum logic [2:0] {
        SPC_ST_RESET = 3'b001,
        SPC_ST_CAPTURE = 3'b010,
        SPC_ST_HOLD = 3'b100
    } spc_state_type;
endpackage

/* File: rtl/spc_sync.sv */
`timescale 1ns/10ps
module spc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // two-stage synchroniser, first stage feeds only the second
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
    assign sync_out = sync_q;
endmodule

/* File: rtl/spc_top.sv */
// Contract
// R1 - Both capture registers are loaded once when reset is released and then held until the next reset.
// R2 - Bit 7 of the soft record holds the select pin level from the last reset, 0 soft mode, 1 hard mode.
// R3 - In soft mode bits 6 to 4 of the soft record hold a code made from pins 3 and 2.
// R4 - The soft code is 0 to 5 for pin 3 low/high crossed with pin 2 low/mid/high.
// R5 - In hard mode the soft code field reads zero.
// R6 - In hard mode bits 7 to 2 of the hard record hold the six pin levels from the last reset.
// R7 - The hard code is the binary value of pins 5 to 0 with pin 5 most significant.
// R8 - In soft mode the hard code field reads zero.
// R9 - Reserved bits read zero and writes to both records have no effect.
// R10 - Pin 2 arrives already decoded as a low, mid or high level.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/10ps
module spc_top (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic config_select_pin,
    input wire logic [5:0] strap_pins,
    input wire logic [1:0] mid_level_input,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [spc_pkg::SPC_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import spc_pkg::*;

    logic [8:0] pins_sync;
    logic sel_sync;
    logic [5:0] gpio_sync;
    logic [1:0] lvl_sync;
    spc_state_type state_q;
    spc_state_type state_d;
    logic sel_q;
    logic [2:0] soft_q;
    logic [5:0] hard_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [2:0] soft_code;
    logic [1:0] pin2_rank;
    logic capture;
    logic bus_req;
    logic hit_soft;
    logic hit_hard;
    logic [7:0] soft_word;
    logic [7:0] hard_word;
    logic [31:0] rd_data;
    // next values and per-pin capture
    logic fill_q;
    logic sel_d;
    logic [2:0] soft_d;
    logic [5:0] hard_d;
    logic ack_d;
    logic [31:0] dat_d;
    wire logic [5:0] hard_pick;
    logic rd_take;

    // straps come from board pins, so synchronise them first
    spc_sync #(.WIDTH(9)) u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in({config_select_pin, mid_level_input, strap_pins}),
        .sync_out(pins_sync)
    );
    // split the synchronised bundle
    assign sel_sync = pins_sync[8];
    assign lvl_sync = pins_sync[7:6];
    assign gpio_sync = pins_sync[5:0];

    // one spare cycle after release so the reset zeros leave the synchroniser
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            fill_q <= 1'b0;
        end
        else
        begin
            fill_q <= 1'b1;
        end
    end

    // capture sequencer: wait for pins to pass the synchroniser, load once
    always_comb
    begin
        case (state_q)
            SPC_ST_RESET: state_d = fill_q ? SPC_ST_CAPTURE : SPC_ST_RESET;
            SPC_ST_CAPTURE: state_d = SPC_ST_HOLD;
            SPC_ST_HOLD: state_d = SPC_ST_HOLD;
            default: state_d = SPC_ST_RESET;
        endcase
    end
    // R1 single capture point
    assign capture = (state_q == SPC_ST_CAPTURE);

    // sequencer state, back to idle on every reset
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            state_q <= SPC_ST_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // R10 pre-decoded pin 2 level
    assign pin2_rank = (lvl_sync == SPC_LVL_MID) ? 2'h1 :
                       (lvl_sync == SPC_LVL_HIGH) ? 2'h2 : 2'h0;
    // R4 three-level soft code
    assign soft_code = (gpio_sync[3] ? 3'h3 : 3'h0) + {1'b0, pin2_rank};

    // R8 hard field zero in soft mode
    // R7 each pin keeps its own bit position
    for (genvar b = 0; b < 6; b++)
    begin : g_hard
        assign hard_pick[b] = sel_sync && gpio_sync[b];
    end

    // R1 next values: load at the capture point, hold otherwise
    assign sel_d = capture ? sel_sync : sel_q;
    // R5 soft field zero in hard mode
    assign soft_d = !capture ? soft_q : (sel_sync ? SPC_SOFT_RST : soft_code);
    assign hard_d = capture ? hard_pick : hard_q;

    // latched mode select
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            sel_q <= SPC_SEL_RST;
        end
        else
        begin
            sel_q <= sel_d;
        end
    end

    // soft code record
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            soft_q <= SPC_SOFT_RST;
        end
        else
        begin
            soft_q <= soft_d;
        end
    end

    // hard code record
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            hard_q <= SPC_HARD_RST;
        end
        else
        begin
            hard_q <= hard_d;
        end
    end

    // R2 select bit
    // R3 soft field placement
    // R9 reserved bits zero
    assign soft_word = {sel_q, soft_q, 4'h0};
    // R6 hard field placement
    // R7 binary pin value
    assign hard_word = {hard_q, 2'h0};

    // wishbone decode; unmapped reads return zero
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign hit_soft = (wb_adr_i == SPC_SOFT_ADDR);
    assign hit_hard = (wb_adr_i == SPC_HARD_ADDR);
    // R9 upper bytes read zero
    assign rd_data = hit_soft ? {24'h000000, soft_word} :
                     hit_hard ? {24'h000000, hard_word} : 32'h00000000;
    // R9 writes acknowledged and discarded, only reads load data
    assign rd_take = bus_req && !wb_we_i;
    assign ack_d = bus_req;
    assign dat_d = rd_take ? rd_data : dat_q;

    // one-wait ack, a single-cycle pulse
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= ack_d;
        end
    end

    // read data stands until the next read is taken
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            dat_q <= 32'h00000000;
        end
        else
        begin
            dat_q <= dat_d;
        end
    end

    // outputs come straight from flip-flops
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
endmodule

/* File: dv/spc_asserts.sv */
`timescale 1ns/10ps
module spc_asserts
    import spc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    // read answers per record
    wire rd = wb_ack_o && !wb_we_i;
    wire rs = rd && wb_adr_i == SPC_SOFT_ADDR;
    wire rh = rd && wb_adr_i == SPC_HARD_ADDR;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // answer timing and read contents
    ack_due_a: assert property (wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    top_zero_a: assert property (rd |-> !wb_dat_o[31:8]) else $error("upper");
    soft_rsv_a: assert property (rs |-> !wb_dat_o[3:0]) else $error("soft rsv");
    hard_rsv_a: assert property (rh |-> !wb_dat_o[1:0]) else $error("hard rsv");
    soft_code_a: assert property (rs |-> wb_dat_o[6:4] < 3'h6) else $error("code");
    soft_off_a: assert property (rs && wb_dat_o[7] |-> !wb_dat_o[6:4]) else $error("off");
    no_map_a: assert property (rd && !rs && !rh |-> !wb_dat_o) else $error("unmapped");
    cover property (rs && wb_dat_o[7]);
    cover property (rh && wb_dat_o[7:2] == 6'h3f);
    cover property (wb_ack_o && wb_we_i);
endmodule

/* File: dv/spc_straps.sv */
`timescale 1ns/10ps
module spc_straps (
    input wire logic hard_mode,
    input wire logic [5:0] code,
    output logic config_select_pin,
    output logic [5:0] strap_pins,
    output logic [1:0] mid_level_input
);
    wire logic p3 = code[2:0] > 3'h2;
    wire logic [2:0] lvl = code[2:0] - (p3 ? 3'h3 : 3'h0);
    // spare pins high in soft mode to expose leakage
    assign config_select_pin = hard_mode;
    assign strap_pins = hard_mode ? code : {2'h3, p3, lvl == 3'h2, 2'h3};
    assign mid_level_input = hard_mode ? {code[2], 1'b0} : lvl[1:0];
endmodule

/* File: dv/strap_pin_capture_tb_top.sv */
`timescale 1ns/10ps
module strap_pin_capture_tb_top;
    import spc_pkg::*;
    logic ref_clk = 0, resetn = 0, req = 0, we = 0, hm = 0;
    logic [5:0] adr = 0, code = 0;
    logic [31:0] rdat;
    wire sp, ack;
    wire [5:0] pins;
    wire [1:0] mid;
    wire [31:0] dat;
    int n_fail = 0, check_count = 0, cycles = 0;
    spc_straps board (.hard_mode(hm), .code(code), .config_select_pin(sp), .strap_pins(pins),
        .mid_level_input(mid));
    spc_top uut (.ref_clk(ref_clk), .resetn(resetn), .config_select_pin(sp), .strap_pins(pins),
        .mid_level_input(mid), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(32'hffff_ffff), .wb_dat_o(dat), .wb_ack_o(ack));
    // clock and hang guard
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (++cycles == 3000) tally_and_finish(1);
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        n_fail += int'(seen !== exp);
        if (seen !== exp) $display("FAIL %0t %h %h", $time, seen, exp);
    endtask
    task bus(input logic w, input logic [5:0] a);
        @(posedge ref_clk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        do @(posedge ref_clk); while (ack !== 1'b1);
        rdat = dat;
        req <= 1'b0;
        @(posedge ref_clk);
    endtask
    // straps applied through reset, then disturbed after capture
    task t_strap(input logic h, input logic [5:0] c);
        @(posedge ref_clk);
        resetn <= 1'b0;
        hm <= h;
        code <= c;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        hm <= ~h;
        code <= ~c;
        repeat (4) @(posedge ref_clk);
        bus(1'b0, SPC_SOFT_ADDR);
        chk(rdat, h ? 32'h80 : {25'h0, c[2:0], 4'h0});
        bus(1'b0, SPC_HARD_ADDR);
        chk(rdat, h ? {24'h0, c, 2'h0} : 32'h0);
    endtask
    task t_write;
        bus(1'b1, SPC_SOFT_ADDR);
        bus(1'b0, SPC_SOFT_ADDR);
        chk(rdat, 32'h80);
        bus(1'b1, SPC_HARD_ADDR);
        bus(1'b0, SPC_HARD_ADDR);
        chk(rdat, {24'h0, 6'h3f, 2'h0});
        bus(1'b0, 6'h10);
        chk(rdat, 32'h0);
    endtask
    task tally_and_finish(input int extra);
        n_fail += extra;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // every soft code, then hard codes 0x00, 0x15, 0x2a and 0x3f
    initial
    begin
        for (int i = 0; i < 6; i++) t_strap(1'b0, 6'(i));
        for (int i = 0; i < 4; i++) t_strap(1'b1, 6'(21 * i));
        t_write();
        tally_and_finish(0);
    end
endmodule
bind spc_top spc_asserts chk_i (.ref_clk(ref_clk), .resetn(resetn), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
